/* logic/aid_pkg.sv */
/*
 Package for the instruction decode and address unit: opcode fields,
 addressing modes, operations, lengths and reset values.
 Assumes an 8-bit CPU with a 16-bit byte address space.
*/
package aid_pkg;
    typedef enum logic [7:0] {
        AID_AM_INH = 8'h01,
        AID_AM_IMM = 8'h02,
        AID_AM_DIR = 8'h04,
        AID_AM_EXT = 8'h08,
        AID_AM_IX  = 8'h10,
        AID_AM_IX1 = 8'h20,
        AID_AM_IX2 = 8'h40,
        AID_AM_REL = 8'h80
    } aid_mode_e;

    typedef enum logic [3:0] {
        AID_OP_NONE, AID_OP_SUB, AID_OP_CMP, AID_OP_SBB, AID_OP_XCMP, AID_OP_AND,
        AID_OP_BIT, AID_OP_LDACC, AID_OP_STACC, AID_OP_XOR, AID_OP_ADC, AID_OP_OR,
        AID_OP_ADD, AID_OP_LDIDX, AID_OP_STIDX, AID_OP_MUL
    } aid_rm_e;

    typedef enum logic [3:0] {
        AID_RMW_NEG, AID_RMW_COM, AID_RMW_LSR, AID_RMW_ROR, AID_RMW_ASR,
        AID_RMW_ASL, AID_RMW_ROL, AID_RMW_DEC, AID_RMW_INC, AID_RMW_TEST,
        AID_RMW_CLR, AID_RMW_BITSET, AID_RMW_BITCLR, AID_RMW_NONE
    } aid_rmw_e;

    localparam int          AID_NUM_INSTR   = 62;
    localparam logic [7:0]  AID_ZERO_PAGE   = 8'h00;
    localparam logic [15:0] AID_PC_RESET    = 16'h0000;
    localparam logic [7:0]  AID_REG_RESET   = 8'h00;
    localparam logic [7:0]  AID_MUL_OPCODE  = 8'h42;
    localparam logic [7:0]  AID_CSET_OPCODE = 8'h99;
    localparam logic [7:0]  AID_AINC_OPCODE = 8'h4C;
    localparam logic [1:0]  AID_LEN_1       = 2'h1;
    localparam logic [1:0]  AID_LEN_2       = 2'h2;
    localparam logic [1:0]  AID_LEN_3       = 2'h3;
    localparam int          AID_HI_MSB      = 7;
    localparam int          AID_HI_LSB      = 4;
endpackage

/* logic/aid_alu.sv */
/*
 Operation unit: unsigned multiply, register/memory arithmetic and
 read-modify-write results. Purely combinational.
 Assumes operands are stable for the cycle in which the result is used.
*/
`timescale 1ns/1ps
module aid_alu
    import aid_pkg::*;
(
    input  wire aid_rm_e    rm_op,
    input  wire aid_rmw_e   rmw_op,
    input  wire logic [2:0] bit_num,
    input  wire logic [7:0] acc,
    input  wire logic [7:0] idx,
    input  wire logic [7:0] opnd,
    input  wire logic       carry_in,
    output logic      [7:0] rm_acc,
    output logic      [7:0] rm_idx,
    output logic            rm_carry,
    output logic            rm_wr_mem,
    output logic      [7:0] rmw_val,
    output logic            rmw_carry,
    output logic            rmw_wb
);
    logic [15:0] product;
    logic [8:0]  sum;

    always_comb begin
        product   = {8'h00, acc} * {8'h00, idx};
        sum       = 9'h000;
        rm_acc    = acc;
        rm_idx    = idx;
        rm_carry  = carry_in;
        rm_wr_mem = 1'b0;
        unique case (rm_op)
            AID_OP_ADD: begin
                sum = {1'b0, acc} + {1'b0, opnd};
                rm_acc = sum[7:0];
                rm_carry = sum[8];
            end
            AID_OP_ADC: begin
                sum = {1'b0, acc} + {1'b0, opnd} + {8'h00, carry_in};
                rm_acc = sum[7:0];
                rm_carry = sum[8];
            end
            AID_OP_SUB, AID_OP_CMP: begin
                sum = {1'b0, acc} - {1'b0, opnd};
                if (rm_op == AID_OP_SUB) rm_acc = sum[7:0];
                rm_carry = sum[8];
            end
            AID_OP_SBB: begin
                sum = {1'b0, acc} - {1'b0, opnd} - {8'h00, carry_in};
                rm_acc = sum[7:0];
                rm_carry = sum[8];
            end
            AID_OP_XCMP: begin
                sum = {1'b0, idx} - {1'b0, opnd};
                rm_carry = sum[8];
            end
            AID_OP_AND: rm_acc = acc & opnd;
            AID_OP_BIT: rm_acc = acc;
            AID_OP_XOR: rm_acc = acc ^ opnd;
            AID_OP_OR: rm_acc = acc | opnd;
            AID_OP_LDACC: rm_acc = opnd;
            AID_OP_LDIDX: rm_idx = opnd;
            AID_OP_STACC, AID_OP_STIDX: rm_wr_mem = 1'b1;
            AID_OP_MUL: begin
                rm_idx = product[15:8]; // RL2
                rm_acc = product[7:0];  // RL2
                rm_carry = 1'b0;
            end
            default: rm_acc = acc;
        endcase
    end

    always_comb begin
        rmw_val   = opnd;
        rmw_carry = carry_in;
        rmw_wb    = 1'b1; // RL14
        unique case (rmw_op)
            AID_RMW_NEG: begin
                rmw_val = 8'h00 - opnd;
                rmw_carry = |opnd;
            end
            AID_RMW_COM: begin
                rmw_val = ~opnd;
                rmw_carry = 1'b1;
            end
            AID_RMW_LSR: {rmw_val, rmw_carry} = {1'b0, opnd};
            AID_RMW_ROR: {rmw_val, rmw_carry} = {carry_in, opnd};
            AID_RMW_ASR: {rmw_val, rmw_carry} = {opnd[7], opnd};
            AID_RMW_ASL: {rmw_carry, rmw_val} = {opnd, 1'b0}; // RL15
            AID_RMW_ROL: {rmw_carry, rmw_val} = {opnd, carry_in};
            AID_RMW_DEC: rmw_val = opnd - 8'h01;
            AID_RMW_INC: rmw_val = opnd + 8'h01;
            AID_RMW_TEST: rmw_wb = 1'b0; // RL17
            AID_RMW_CLR: rmw_val = 8'h00;
            AID_RMW_BITSET: rmw_val = opnd | (8'h01 << bit_num);
            AID_RMW_BITCLR: rmw_val = opnd & ~(8'h01 << bit_num);
            default: rmw_wb = 1'b0;
        endcase
    end
endmodule // aid_alu

/* logic/aid_core.sv */
/*
 Instruction decode and effective-address unit of an 8-bit CPU.
 Fetches opcode and operand bytes, forms addresses, runs register/memory
 and read-modify-write operations. Assumes a byte-wide memory that
 answers a read in the cycle after the request (data valid one cycle later).
*/
// Function
// RL1: Sixty-two instructions over exactly eight addressing modes.
// RL2: Multiply A by X unsigned; high byte to X, low to A.
// RL3: Inherent opcodes are one byte with no operand address.
// RL4: Immediate opcodes take one data byte; no address formed.
// RL5: Direct uses one address byte with high byte zero.
// RL6: Extended takes high then low address byte, three bytes total.
// RL7: Indexed no offset uses X as address, high byte zero.
// RL8: Indexed 8-bit adds X and offset byte unsigned, two bytes.
// RL9: Indexed 16-bit adds X to high-first offset, three bytes.
// RL10: Taken branch adds signed offset to PC; else fall through.
// RL11: Relative mode only for branches, offset from next instruction.
// RL12: Register/memory ops combine A or X with a memory byte.
// RL13: Register/memory set covers add, logic, compare, loads, stores, multiply.
// RL14: Read-modify-write reads, modifies and writes back same place.
// RL15: RMW set covers shifts, clear, complement, inc, dec, negate, rotates, bits.
// RL16: Single-bit set and clear use direct addressing only.
// RL17: Negative-or-zero test never writes its operand back.
// RL18: Software avoids RMW on write-only registers.
// RL19: Indexed sums are unsigned with carry into the high byte.
`timescale 1ns/1ps
module aid_core
    import aid_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  mem_rdata,
    output logic      [15:0] mem_addr,
    output logic             mem_rd,
    output logic             mem_wr,
    output logic      [7:0]  mem_wdata,
    output logic      [7:0]  acc_out,
    output logic      [7:0]  idx_out,
    output logic      [15:0] pc_out,
    output logic             carry_out,
    output logic      [7:0]  mode_out
);
    typedef enum logic [6:0] {
        AID_ST_FETCH = 7'h01,
        AID_ST_OP1   = 7'h02,
        AID_ST_OP2   = 7'h04,
        AID_ST_READ  = 7'h08,
        AID_ST_EXEC  = 7'h10,
        AID_ST_WRITE = 7'h20,
        AID_ST_WAIT  = 7'h40
    } aid_state_e;

    aid_state_e  state_ff, nxt_state;
    logic [15:0] pc_ff, nxt_pc;
    logic [7:0]  acc_ff, nxt_acc, idx_ff, nxt_idx;
    logic        carry_ff, nxt_carry;
    logic [7:0]  opc_ff, nxt_opc, b1_ff, nxt_b1, opnd_ff, nxt_opnd;
    logic [15:0] addr_ff, nxt_addr;
    logic        rd_ff, nxt_rd, wr_ff, nxt_wr;
    logic [7:0]  wdata_ff, nxt_wdata;
    aid_mode_e   mode_ff, nxt_mode;
    aid_state_e  ret_ff, nxt_ret;

    aid_mode_e   dmode;
    aid_rm_e     rm_op;
    aid_rmw_e    rmw_op;
    logic        is_rmw, is_branch, take_branch, reg_target_x;
    logic [7:0]  rm_acc, rm_idx, rmw_val;
    logic        rm_carry, rm_wr_mem, rmw_carry, rmw_wb;

    // Addressing mode from the opcode's high nibble
    function automatic aid_mode_e mode_of(input logic [7:0] op);
        unique case (op[7:4])
            4'h0, 4'h1, 4'h3, 4'hB: mode_of = AID_AM_DIR;
            4'h2:                   mode_of = AID_AM_REL;
            4'h4, 4'h5, 4'h8, 4'h9: mode_of = AID_AM_INH;
            4'h6, 4'hE:             mode_of = AID_AM_IX1;
            4'h7, 4'hF:             mode_of = AID_AM_IX;
            4'hA:                   mode_of = AID_AM_IMM;
            4'hC:                   mode_of = AID_AM_EXT;
            default:                mode_of = AID_AM_IX2;
        endcase
    endfunction

    // Bytes an opcode occupies
    function automatic logic [1:0] len_of(input aid_mode_e m);
        unique case (m)
            AID_AM_INH, AID_AM_IX:                         len_of = AID_LEN_1; // RL3 RL7
            AID_AM_IMM, AID_AM_DIR, AID_AM_IX1, AID_AM_REL: len_of = AID_LEN_2; // RL4 RL5 RL8
            default:                                       len_of = AID_LEN_3; // RL6 RL9
        endcase
    endfunction

    assign dmode = mode_of(opc_ff); // RL1
    assign is_branch = (opc_ff[7:4] == 4'h2); // RL11
    assign is_rmw = (opc_ff[7:4] <= 4'h7) && !is_branch && (opc_ff[7:4] != 4'h0);
    assign reg_target_x = (opc_ff[7:4] == 4'h5);

    // Branch always and conditions on carry only; others fall through here
    always_comb begin
        unique case (opc_ff[3:0])
            4'h0:    take_branch = 1'b1;
            4'h4:    take_branch = !carry_ff;
            4'h5:    take_branch = carry_ff;
            default: take_branch = 1'b0;
        endcase
    end

    always_comb begin
        rm_op = AID_OP_NONE;
        if (opc_ff == AID_MUL_OPCODE) begin
            rm_op = AID_OP_MUL;
        end else if (opc_ff[7:4] >= 4'hA) begin // RL12 RL13
            unique case (opc_ff[3:0])
                4'h0: rm_op = AID_OP_SUB;
                4'h1: rm_op = AID_OP_CMP;
                4'h2: rm_op = AID_OP_SBB;
                4'h3: rm_op = AID_OP_XCMP;
                4'h4: rm_op = AID_OP_AND;
                4'h5: rm_op = AID_OP_BIT;
                4'h6: rm_op = AID_OP_LDACC;
                4'h7: rm_op = AID_OP_STACC;
                4'h8: rm_op = AID_OP_XOR;
                4'h9: rm_op = AID_OP_ADC;
                4'hA: rm_op = AID_OP_OR;
                4'hB: rm_op = AID_OP_ADD;
                4'hE: rm_op = AID_OP_LDIDX;
                4'hF: rm_op = AID_OP_STIDX;
                default: rm_op = AID_OP_NONE;
            endcase
        end
    end

    always_comb begin
        rmw_op = AID_RMW_NONE;
        if (opc_ff[7:4] == 4'h1) begin
            rmw_op = opc_ff[0] ? AID_RMW_BITCLR : AID_RMW_BITSET; // RL16
        end else if (is_rmw) begin // RL15
            unique case (opc_ff[3:0])
                4'h0: rmw_op = AID_RMW_NEG;
                4'h3: rmw_op = AID_RMW_COM;
                4'h4: rmw_op = AID_RMW_LSR;
                4'h6: rmw_op = AID_RMW_ROR;
                4'h7: rmw_op = AID_RMW_ASR;
                4'h8: rmw_op = AID_RMW_ASL;
                4'h9: rmw_op = AID_RMW_ROL;
                4'hA: rmw_op = AID_RMW_DEC;
                4'hC: rmw_op = AID_RMW_INC;
                4'hD: rmw_op = AID_RMW_TEST;
                4'hF: rmw_op = AID_RMW_CLR;
                default: rmw_op = AID_RMW_NONE;
            endcase
        end
    end

    aid_alu u_alu (
        .rm_op     (rm_op),
        .rmw_op    (rmw_op),
        .bit_num   (opc_ff[3:1]),
        .acc       (acc_ff),
        .idx       (idx_ff),
        .opnd      (opnd_ff),
        .carry_in  (carry_ff),
        .rm_acc    (rm_acc),
        .rm_idx    (rm_idx),
        .rm_carry  (rm_carry),
        .rm_wr_mem (rm_wr_mem),
        .rmw_val   (rmw_val),
        .rmw_carry (rmw_carry),
        .rmw_wb    (rmw_wb)
    );

    always_comb begin
        nxt_state = state_ff;
        nxt_pc    = pc_ff;
        nxt_acc   = acc_ff;
        nxt_idx   = idx_ff;
        nxt_carry = carry_ff;
        nxt_opc   = opc_ff;
        nxt_b1    = b1_ff;
        nxt_opnd  = opnd_ff;
        nxt_addr  = addr_ff;
        nxt_rd    = 1'b0;
        nxt_wr    = 1'b0;
        nxt_wdata = wdata_ff;
        nxt_mode  = mode_ff;
        nxt_ret   = ret_ff;
        unique case (state_ff)
            AID_ST_FETCH: begin
                nxt_addr  = pc_ff;
                nxt_rd    = 1'b1;
                nxt_pc    = pc_ff + 16'h0001;
                nxt_ret   = AID_ST_OP1;
                nxt_state = AID_ST_WAIT;
            end
            AID_ST_WAIT: begin
                nxt_state = ret_ff;
            end
            AID_ST_OP1: begin
                if (ret_ff == AID_ST_OP1 && !rd_ff) begin
                    nxt_opc  = mem_rdata;
                    nxt_mode = mode_of(mem_rdata);
                end
                nxt_ret = AID_ST_OP2;
                if (len_of(mode_of(mem_rdata)) == AID_LEN_1) begin
                    nxt_state = AID_ST_READ;
                end else begin
                    nxt_addr  = pc_ff;
                    nxt_rd    = 1'b1;
                    nxt_pc    = pc_ff + 16'h0001;
                    nxt_state = AID_ST_WAIT;
                end
            end
            AID_ST_OP2: begin
                nxt_b1 = mem_rdata;
                if (len_of(dmode) == AID_LEN_3) begin
                    nxt_addr  = pc_ff;
                    nxt_rd    = 1'b1;
                    nxt_pc    = pc_ff + 16'h0001;
                    nxt_ret   = AID_ST_READ;
                    nxt_state = AID_ST_WAIT;
                end else begin
                    nxt_state = AID_ST_READ;
                end
            end
            AID_ST_READ: begin
                nxt_state = AID_ST_EXEC;
                unique case (dmode)
                    AID_AM_INH: nxt_opnd = reg_target_x ? idx_ff : acc_ff; // RL3
                    AID_AM_IMM: nxt_opnd = b1_ff; // RL4
                    AID_AM_REL: nxt_opnd = b1_ff;
                    AID_AM_DIR: nxt_addr = {AID_ZERO_PAGE, b1_ff}; // RL5
                    AID_AM_EXT: nxt_addr = {b1_ff, mem_rdata}; // RL6
                    AID_AM_IX:  nxt_addr = {AID_ZERO_PAGE, idx_ff}; // RL7
                    AID_AM_IX1: nxt_addr = {8'h00, b1_ff} + {8'h00, idx_ff}; // RL8 RL19
                    default:    nxt_addr = {b1_ff, mem_rdata} + {8'h00, idx_ff}; // RL9 RL19
                endcase
                if (dmode inside {AID_AM_DIR, AID_AM_EXT, AID_AM_IX, AID_AM_IX1,
                                  AID_AM_IX2} && !(rm_op inside {AID_OP_STACC, AID_OP_STIDX})) begin
                    nxt_rd    = 1'b1;
                    nxt_ret   = AID_ST_EXEC;
                    nxt_state = AID_ST_WAIT;
                end
            end
            AID_ST_EXEC: begin
                nxt_state = AID_ST_FETCH;
                if (ret_ff == AID_ST_EXEC) begin
                    nxt_opnd = mem_rdata;
                    nxt_ret  = AID_ST_WRITE;
                    nxt_state = AID_ST_EXEC;
                end else if (is_branch) begin
                    if (take_branch) begin
                        nxt_pc = pc_ff + {{8{b1_ff[7]}}, b1_ff}; // RL10 RL11
                    end
                end else if (opc_ff == AID_CSET_OPCODE) begin
                    nxt_carry = 1'b1; // RL3
                end else if (rmw_op != AID_RMW_NONE) begin
                    nxt_carry = rmw_carry;
                    if (rmw_wb) begin // RL14 RL17
                        if (dmode == AID_AM_INH) begin
                            if (reg_target_x) nxt_idx = rmw_val;
                            else nxt_acc = rmw_val;
                        end else begin
                            nxt_wdata = rmw_val;
                            nxt_state = AID_ST_WRITE;
                        end
                    end
                end else if (rm_op != AID_OP_NONE) begin
                    nxt_acc   = rm_acc;
                    nxt_idx   = rm_idx;
                    nxt_carry = rm_carry;
                    if (rm_wr_mem) begin
                        nxt_wdata = (rm_op == AID_OP_STIDX) ? idx_ff : acc_ff;
                        nxt_state = AID_ST_WRITE;
                    end
                end
            end
            AID_ST_WRITE: begin
                nxt_wr    = 1'b1;
                nxt_ret   = AID_ST_FETCH;
                nxt_state = AID_ST_FETCH;
            end
            default: nxt_state = AID_ST_FETCH;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= AID_ST_FETCH;
            pc_ff    <= AID_PC_RESET;
            acc_ff   <= AID_REG_RESET;
            idx_ff   <= AID_REG_RESET;
            carry_ff <= 1'b0;
            opc_ff   <= AID_REG_RESET;
            b1_ff    <= AID_REG_RESET;
            opnd_ff  <= AID_REG_RESET;
            addr_ff  <= AID_PC_RESET;
            rd_ff    <= 1'b0;
            wr_ff    <= 1'b0;
            wdata_ff <= AID_REG_RESET;
            mode_ff  <= AID_AM_INH;
            ret_ff   <= AID_ST_FETCH;
        end else begin
            state_ff <= nxt_state;
            pc_ff    <= nxt_pc;
            acc_ff   <= nxt_acc;
            idx_ff   <= nxt_idx;
            carry_ff <= nxt_carry;
            opc_ff   <= nxt_opc;
            b1_ff    <= nxt_b1;
            opnd_ff  <= nxt_opnd;
            addr_ff  <= nxt_addr;
            rd_ff    <= nxt_rd;
            wr_ff    <= nxt_wr;
            wdata_ff <= nxt_wdata;
            mode_ff  <= nxt_mode;
            ret_ff   <= nxt_ret;
        end
    end

    assign mem_addr  = addr_ff;
    assign mem_rd    = rd_ff;
    assign mem_wr    = wr_ff;
    assign mem_wdata = wdata_ff;
    assign acc_out   = acc_ff;
    assign idx_out   = idx_ff;
    assign pc_out    = pc_ff;
    assign carry_out = carry_ff;
    assign mode_out  = mode_ff;

    ix1_range_a: assert property (@(posedge clk) disable iff (rst) // RL8
        (state_ff == AID_ST_READ && dmode == AID_AM_IX1) |=>
        (addr_ff == {8'h00, $past(b1_ff)} + {8'h00, $past(idx_ff)}))
        else $error("indexed 8-bit address wrong");
    dir_page_a: assert property (@(posedge clk) disable iff (rst) // RL5
        (state_ff == AID_ST_READ && dmode == AID_AM_DIR) |=> (addr_ff[15:8] == 8'h00))
        else $error("direct high byte not zero");
    ix_page_a: assert property (@(posedge clk) disable iff (rst) // RL7
        (state_ff == AID_ST_READ && dmode == AID_AM_IX) |=> (addr_ff == {8'h00, $past(idx_ff)}))
        else $error("indexed address wrong");
    mul_result_a: assert property (@(posedge clk) disable iff (rst) // RL2
        (state_ff == AID_ST_EXEC && ret_ff != AID_ST_EXEC && rm_op == AID_OP_MUL) |=>
        ({idx_ff, acc_ff} == $past(acc_ff) * $past(idx_ff)))
        else $error("multiply result wrong");
    test_nowrite_a: assert property (@(posedge clk) disable iff (rst) // RL17
        (state_ff == AID_ST_EXEC && ret_ff != AID_ST_EXEC && rmw_op == AID_RMW_TEST) |=>
        ##1 !mem_wr)
        else $error("test wrote back");
    branch_pc_a: assert property (@(posedge clk) disable iff (rst) // RL10
        (state_ff == AID_ST_EXEC && ret_ff != AID_ST_EXEC && is_branch && !take_branch) |=>
        $stable(pc_ff))
        else $error("untaken branch moved pc");
    ext_order_a: assert property (@(posedge clk) disable iff (rst) // RL6
        (state_ff == AID_ST_READ && dmode == AID_AM_EXT) |=>
        (addr_ff == {$past(b1_ff), $past(mem_rdata)}))
        else $error("extended address order wrong");
    rmw_write_a: assert property (@(posedge clk) disable iff (rst) // RL14
        (state_ff == AID_ST_WRITE) |=> mem_wr ##1 (state_ff inside {AID_ST_WAIT, AID_ST_FETCH}))
        else $error("write-back missing");
endmodule // aid_core

/* dv/aid_mem_model.sv */
/*
 Behavioural byte-wide memory on the far side of the decode unit.
 Assumes read data is wanted one cycle after the read strobe and held
 two more cycles; outside that window the bus toggles every cycle.
*/
`timescale 1ns/1ps
module aid_mem_model (
    input  wire logic        clk,
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic [7:0]  mem_wdata,
    output logic      [7:0]  mem_rdata
);
    logic [7:0] mem [0:65535];
    logic [1:0] age;

    initial begin
        mem_rdata = 8'h00;
        age = 2'd2;
    end

    always @(posedge clk) begin
        if (mem_rd === 1'b1) begin
            mem_rdata <= #1 mem[mem_addr];
            age       <= 2'd0;
        end else if (age < 2'd2) begin
            age <= age + 2'd1;
        end else begin
            // Hold time over, no stale value
            mem_rdata <= #1 ~mem_rdata;
        end
        if (mem_wr === 1'b1) begin
            mem[mem_addr] <= mem_wdata;
        end
    end
endmodule // aid_mem_model

/* dv/test_cpu_addressing_and_instruction_types.sv */
/*
 Self-checking bench: loads a program into the memory model, queues the
 expected memory writes and compares each write as it appears.
 Assumes program execution starts at address 0000 after reset.
*/
`timescale 1ns/1ps
module test_cpu_addressing_and_instruction_types;
    import aid_pkg::*;
    logic        clk, rst, mem_rd, mem_wr, carry_out;
    logic [7:0]  mem_rdata, mem_wdata, acc_out, idx_out, mode_out;
    logic [15:0] mem_addr, pc_out, prod;
    logic [7:0]  a, x, b, d, xi, xr, r, e;
    logic [8:0]  s;
    logic        c;
    logic [7:0]  rmo [9] = '{8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA8, 8'hA9, 8'hAA};
    logic [23:0] exp_q [$];
    logic [7:0]  ops [13] = '{8'h3C, 8'h3D, 8'h3F, 8'h16, 8'h1B, 8'h33,
                              8'h30, 8'h3A, 8'h34, 8'h38, 8'h37, 8'h39, 8'h36};
    int          fails, n_checks, pp, i;
    integer      seed;

    aid_core aid_core_inst (.clk(clk), .rst(rst), .mem_rdata(mem_rdata),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata), .acc_out(acc_out), .idx_out(idx_out),
        .pc_out(pc_out), .carry_out(carry_out), .mode_out(mode_out));
    aid_mem_model aid_mem_model_inst (.clk(clk), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata));

    always #2 clk = ~clk;

    task automatic check(input string what, input logic [23:0] want,
                         input logic [23:0] got);
        n_checks++;
        if (got !== want) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, got);
        end
    endtask

    task automatic put(input logic [23:0] v, input int n);
        for (int k = 0; k < n; k++) begin
            aid_mem_model_inst.mem[pp] = v[23 - 8 * k -: 8];
            pp++;
        end
    endtask

    task automatic note(input logic [15:0] ad, input logic [7:0] dv);
        exp_q.push_back({ad, dv});
    endtask

    task automatic complete_run;
        if (fails == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Oldest expected write against each write seen
    always @(posedge clk) begin
        if (rst === 1'b0 && mem_wr === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected write", 24'hxx_xxxx, {mem_addr, mem_wdata});
            end else begin
                check("memory write", exp_q.pop_front(), {mem_addr, mem_wdata});
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        complete_run();
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        fails = 0;
        n_checks = 0;
        pp = 0;
        seed = 32'h4c92;
        a = 8'($random(seed));
        x = 8'($random(seed));
        b = 8'($random(seed));
        d = 8'($random(seed));
        xi = {4'h9, 4'($random(seed))};
        xr = {4'hF, 4'($random(seed))};
        prod = {8'h00, a} * {8'h00, x};
        put({8'hA6, a, 8'h00}, 2);
        put({8'hAE, x, 8'h00}, 2);
        put({8'h42, 16'h0000}, 1);
        put({8'hB7, 8'h80, 8'h00}, 2);
        note(16'h0080, prod[7:0]);
        put({8'hBF, 8'h81, 8'h00}, 2);
        note(16'h0081, prod[15:8]);
        put({8'hAB, b, 8'h00}, 2);
        put({8'hB7, 8'h82, 8'h00}, 2);
        note(16'h0082, prod[7:0] + b);
        aid_mem_model_inst.mem[16'h1234] = d;
        put({8'hC6, 8'h12, 8'h34}, 3);
        put({8'hB7, 8'h83, 8'h00}, 2);
        note(16'h0083, d);
        put({8'hAE, xi, 8'h00}, 2);
        put({8'hF7, 16'h0000}, 1);
        note({8'h00, xi}, d);
        put({8'hAE, xr, 8'h00}, 2);
        put({8'hE7, 8'hFF, 8'h00}, 2);
        note(16'h00FF + {8'h00, xr}, d);
        put({8'hD7, 8'h12, 8'hF0}, 3);
        note(16'h12F0 + {8'h00, xr}, d);
        // Taken branch skips a store, untaken one falls through
        put({8'h99, 16'h0000}, 1);
        put({8'h25, 8'h02, 8'h00}, 2);
        put({8'hB7, 8'h84, 8'h00}, 2);
        put({8'h24, 8'h02, 8'h00}, 2);
        put({8'hB7, 8'h85, 8'h00}, 2);
        note(16'h0085, d);
        // Forward, backward, forward hop
        put({8'h20, 8'h02, 8'h00}, 2);
        put({8'h20, 8'h02, 8'h00}, 2);
        put({8'h20, 8'hFC, 8'h00}, 2);
        put({8'hB7, 8'h86, 8'h00}, 2);
        note(16'h0086, d);
        // Read-modify-write on plain RAM only
        for (i = 0; i < 13; i++) begin
            r = 8'($random(seed));
            aid_mem_model_inst.mem[16'h00A0 + 16'(i)] = r;
            put({ops[i], 8'(8'hA0 + i), 8'h00}, 2);
            case (ops[i])
                8'h3C: e = r + 8'h01;
                8'h3F: e = 8'h00;
                8'h16: e = r | 8'h08;
                8'h1B: e = r & 8'hDF;
                8'h33: e = ~r;
                8'h30: e = 8'h00 - r;
                8'h3A: e = r - 8'h01;
                8'h34: e = {1'b0, r[7:1]};
                8'h38: e = {r[6:0], 1'b0};
                8'h37: {e, c} = {r[7], r};
                8'h39: {c, e} = {r, c};
                8'h36: {e, c} = {c, r};
                default: e = r;
            endcase
            if (ops[i] != 8'h3D) note(16'h00A0 + 16'(i), e);
        end
        // Register/memory immediates chained through the accumulator
        a = d;
        for (i = 0; i < 9; i++) begin
            b = 8'($random(seed));
            put({rmo[i], b, 8'hB7}, 3);
            put({8'(8'hC0 + i), 16'h0000}, 1);
            s = {1'b0, a} - {1'b0, b};
            case (rmo[i])
                8'hA0: {c, a} = s;
                8'hA1: c = s[8];
                8'hA2: {c, a} = s - {8'h00, c};
                8'hA3: begin
                    s = {1'b0, xr} - {1'b0, b};
                    c = s[8];
                end
                8'hA4: a = a & b;
                8'hA8: a = a ^ b;
                8'hA9: {c, a} = {1'b0, a} + {1'b0, b} + {8'h00, c};
                8'hAA: a = a | b;
                default: a = a;
            endcase
            note(16'h00C0 + 16'(i), a);
        end
        put({8'hA6, d, 8'h00}, 2);
        put({8'h4C, 16'h0000}, 1);
        put({8'hB7, 8'hB0, 8'h00}, 2);
        note(16'h00B0, d + 8'h01);
        put({8'h20, 8'hFE, 8'h00}, 2);
        repeat (3) @(posedge clk);
        check("reset pc", {8'h00, AID_PC_RESET}, {8'h00, pc_out});
        #1 rst = 1'b0;
        for (i = 0; i < 5000 && exp_q.size() > 0; i++) @(posedge clk);
        repeat (60) @(posedge clk);
        check("pending writes", 24'h00_0000, 24'(exp_q.size()));
        check("accumulator", {16'h0000, 8'(d + 8'h01)}, {16'h0000, acc_out});
        check("index", {16'h0000, xr}, {16'h0000, idx_out});
        check("mode", {16'h0000, AID_AM_REL}, {16'h0000, mode_out});
        check("carry", {23'h00_0000, c}, {23'h00_0000, carry_out});
        complete_run();
    end
endmodule // test_cpu_addressing_and_instruction_types
